// File: power_state_ctrl.sv
`timescale 1ns/1ps
`include "pwr_consts.svh"
// ************************************************
// Board power state and wake controller
// ************************************************
// Behaviour
// [R1] Short press from off or sleep: working
// [R2] Short press when working: policy sleep/off
// [R3] Press over six seconds: forced soft-off
// [R4] AC return restores saved on/off state
// [R5] LAN wake frame request powers up
// [R6] USB activity wakes from RAM only
// [R7] PCIe wake works from RAM, disk, off
// [R8] RTC alarm wakes from soft-off
// [R9] LAN, PCIe wake ignored after AC return
// [R10] RAM sleep: supply off, LED amber/dark
// [R11] RAM wake returns to working state
// [R12] Press 4-6 s ignored; standby clock timed
module power_state_ctrl #(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic switch_pressed,
    input wire pwr_pkg::wake_req_type wake_in,
    input wire logic rtc_alarm_set,
    input wire pwr_pkg::sleep_policy_type sleep_policy,
    input wire logic os_sleep_req,
    input wire logic restore_last,
    input wire logic last_was_on,
    input wire logic led_dual,
    output pwr_pkg::pwr_state_type state_ff,
    output logic supply_on_ff,
    output logic led_green_ff,
    output logic led_amber_ff
);
    import pwr_pkg::*;

    logic sw_meta_ff, sw_sync_ff;
    wake_req_type wake_meta_ff, wake_sync_ff;
    logic after_ac_ff;
    logic boot_ff;
    logic short_p, long_h;
    logic wake_ok;
    pwr_state_type nxt_state;
    pwr_state_type load_state;
    logic long_rel;

    // ************************************************
    // Helpers
    // ************************************************
    // LAN and PCIe share one gate: both are refused in the first state after AC return
    function automatic logic net_wake(input wake_req_type w, input logic blocked);
        return !blocked && (w.lan || w.pcie);
    endfunction

    // ************************************************
    // Input synchronisers
    // ************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            sw_meta_ff <= 1'b0;
            sw_sync_ff <= 1'b0;
            wake_meta_ff <= '0;
            wake_sync_ff <= '0;
        end else begin
            sw_meta_ff <= switch_pressed;
            sw_sync_ff <= sw_meta_ff;
            wake_meta_ff <= wake_in;
            wake_sync_ff <= wake_meta_ff;
        end
    end

    press_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
        .clock(clock),
        .reset(reset),
        .pressed(sw_sync_ff),
        .release_short(short_p),
        .release_long(long_rel),
        .hold_long(long_h)
    );

    // ************************************************
    // Wake acceptance per state
    // ************************************************
    always_comb begin
        wake_ok = 1'b0;
        case (state_ff)
            ST_RAM: wake_ok = wake_sync_ff.usb // R6
                || net_wake(wake_sync_ff, after_ac_ff); // R5 R7 R9
            ST_DISK: wake_ok = net_wake(wake_sync_ff, after_ac_ff); // R7 R9
            ST_SOFT_OFF: wake_ok = (rtc_alarm_set && wake_sync_ff.rtc) // R8
                || net_wake(wake_sync_ff, after_ac_ff); // R5 R9
            default: wake_ok = 1'b0;
        endcase
    end

    // ************************************************
    // State transitions; long hold has priority in working, RAM and disk
    // ************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_WORKING: begin
                if (long_h) begin
                    nxt_state = ST_SOFT_OFF; // R3
                end else if (short_p || os_sleep_req) begin
                    case (sleep_policy) // R2
                        POL_RAM: nxt_state = ST_RAM;
                        POL_DISK: nxt_state = ST_DISK;
                        default: nxt_state = ST_SOFT_OFF;
                    endcase
                end
            end
            ST_RAM, ST_DISK: begin
                if (long_h) begin
                    nxt_state = ST_SOFT_OFF; // R3
                end else if (short_p || wake_ok) begin
                    nxt_state = ST_WORKING; // R1 R11
                end
            end
            ST_SOFT_OFF: begin
                if (short_p || wake_ok) begin
                    nxt_state = ST_WORKING; // R1
                end
            end
            default: nxt_state = ST_SOFT_OFF;
        endcase
    end

    // Value the state register takes next; outputs follow it so they move with the state
    always_comb begin
        if (boot_ff) begin
            load_state = (restore_last && last_was_on) ? ST_WORKING : ST_SOFT_OFF; // R4
        end else begin
            load_state = nxt_state;
        end
    end

    // Reset stands for AC return; first cycle picks the saved state
    always_ff @(posedge clock) begin
        if (reset) begin
            boot_ff <= 1'b1;
            state_ff <= ST_SOFT_OFF;
        end else begin
            boot_ff <= 1'b0;
            state_ff <= load_state;
        end
    end

    // First state after AC return blocks LAN and PCIe wake until it changes
    always_ff @(posedge clock) begin
        if (reset) begin
            after_ac_ff <= 1'b1;
        end else if (!boot_ff && nxt_state != state_ff) begin
            after_ac_ff <= 1'b0; // R9
        end
    end

    // ************************************************
    // Supply and front panel LED
    // ************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            supply_on_ff <= 1'b0;
            led_green_ff <= 1'b0;
            led_amber_ff <= 1'b0;
        end else begin
            supply_on_ff <= load_state == ST_WORKING; // R10
            led_green_ff <= load_state == ST_WORKING;
            led_amber_ff <= load_state == ST_RAM && led_dual; // R10
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    a_supply_ram: assert property (@(posedge clock) disable iff (reset) // R10
        state_ff == ST_RAM |-> !supply_on_ff)
        else $error("supply on in RAM sleep");
    a_led_single: assert property (@(posedge clock) disable iff (reset) // R10
        state_ff == ST_RAM && !$past(led_dual) |-> !led_amber_ff)
        else $error("amber on single LED");
    a_led_dual: assert property (@(posedge clock) disable iff (reset) // R10
        state_ff == ST_RAM && $past(led_dual) |-> led_amber_ff)
        else $error("amber off on two-colour LED");
    a_supply_work: assert property (@(posedge clock) disable iff (reset) // R1
        state_ff == ST_WORKING |-> supply_on_ff && led_green_ff)
        else $error("supply off while working");
    a_usb_disk: assert property (@(posedge clock) disable iff (reset) // R6
        state_ff == ST_DISK && !short_p && !wake_sync_ff.lan && !wake_sync_ff.pcie
        |=> state_ff != ST_WORKING) else $error("usb woke from disk");
    a_usb_off: assert property (@(posedge clock) disable iff (reset) // R6
        !boot_ff && state_ff == ST_SOFT_OFF && !short_p && !wake_sync_ff.rtc && !wake_sync_ff.lan
        && !wake_sync_ff.pcie |=> state_ff == ST_SOFT_OFF) else $error("usb woke from soft-off");
    a_long_off: assert property (@(posedge clock) disable iff (reset) // R3
        !boot_ff && long_h && state_ff != ST_SOFT_OFF |=> state_ff == ST_SOFT_OFF)
        else $error("long press not off");
    a_short_on: assert property (@(posedge clock) disable iff (reset) // R1
        !boot_ff && short_p && state_ff == ST_SOFT_OFF |=> state_ff == ST_WORKING)
        else $error("short press no power on");
    a_short_sleep: assert property (@(posedge clock) disable iff (reset) // R2
        !boot_ff && short_p && !long_h && state_ff == ST_WORKING |=> state_ff != ST_WORKING)
        else $error("short press no sleep");
    a_ram_wake: assert property (@(posedge clock) disable iff (reset) // R11
        !boot_ff && state_ff == ST_RAM && wake_sync_ff.usb && !long_h |=> state_ff == ST_WORKING)
        else $error("usb no wake from RAM");
    a_ac_block: assert property (@(posedge clock) disable iff (reset) // R9
        !boot_ff && after_ac_ff && state_ff == ST_SOFT_OFF && !short_p && !(rtc_alarm_set && wake_sync_ff.rtc)
        |=> state_ff == ST_SOFT_OFF) else $error("wake after AC loss");
    a_rtc_wake: assert property (@(posedge clock) disable iff (reset) // R8
        !boot_ff && state_ff == ST_SOFT_OFF && rtc_alarm_set && wake_sync_ff.rtc |=> state_ff == ST_WORKING)
        else $error("rtc no wake");
    a_restore: assert property (@(posedge clock) // R4
        $fell(boot_ff) && !reset |-> state_ff == ($past(restore_last && last_was_on) ? ST_WORKING : ST_SOFT_OFF))
        else $error("AC restore wrong");

    // Covers for the main scenarios
    c_ram_usb: cover property (@(posedge clock) state_ff == ST_RAM ##1 state_ff == ST_WORKING);
    c_long: cover property (@(posedge clock) state_ff == ST_WORKING ##1 state_ff == ST_SOFT_OFF);
    c_disk: cover property (@(posedge clock) state_ff == ST_DISK);
    c_long_release: cover property (@(posedge clock) long_rel);
    c_restore_on: cover property (@(posedge clock) $fell(boot_ff) && state_ff == ST_WORKING);
endmodule

// File: power_state_ctrl_tb.sv
`timescale 1ns/1ps
module power_state_ctrl_tb;
    import pwr_pkg::*;
    localparam int MSC = 2;
    logic clock, reset, rtc_alarm_set, restore_last, last_was_on, led_dual, switch_pressed;
    sleep_policy_type sleep_policy;
    wake_req_type wake_in;
    pwr_state_type state_ff;
    logic supply_on_ff, led_green_ff, led_amber_ff;
    logic os_sleep_req;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    // ****************************************
    // Design, source model and clock
    // ****************************************
    power_state_ctrl #(.MS_CYCLES(MSC)) i_power_state_ctrl (
        .clock(clock), .reset(reset), .switch_pressed(switch_pressed), .wake_in(wake_in),
        .rtc_alarm_set(rtc_alarm_set), .sleep_policy(sleep_policy), .os_sleep_req(os_sleep_req),
        .restore_last(restore_last), .last_was_on(last_was_on), .led_dual(led_dual),
        .state_ff(state_ff), .supply_on_ff(supply_on_ff), .led_green_ff(led_green_ff),
        .led_amber_ff(led_amber_ff));
    pwr_src_model #(.MS_CYCLES(MSC)) i_pwr_src_model (
        .clock(clock), .switch_pressed(switch_pressed), .wake_in(wake_in));
    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Runaway guard: whole run plus margin
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            test_done();
        end
    end
    // ****************************************
    // Compare and helper tasks
    // ****************************************
    task automatic check_state(input pwr_state_type exp);
        compares++;
        if (state_ff !== exp) begin
            err_count++;
            $display("ERROR state_ff expected %0d seen %0d", exp, state_ff);
        end
    endtask
    task automatic check_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask
    // Sync plus update takes about three edges; eight leaves margin
    task automatic settle();
        repeat (8) @(posedge clock);
        #1;
    endtask
    task automatic do_reset(input logic rl, input logic on);
        @(posedge clock);
        reset <= 1'b1;
        restore_last <= rl;
        last_was_on <= on;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        settle();
    endtask
    task automatic short_press(input sleep_policy_type p);
        @(posedge clock);
        sleep_policy <= p;
        i_pwr_src_model.press(10);
        settle();
    endtask
    // One-cycle sleep request from the operating system side
    task automatic os_sleep(input sleep_policy_type p);
        @(posedge clock);
        sleep_policy <= p;
        os_sleep_req <= 1'b1;
        @(posedge clock);
        os_sleep_req <= 1'b0;
        settle();
    endtask
    task automatic wake(input logic [3:0] w);
        i_pwr_src_model.wake(wake_req_type'(w));
        settle();
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_off_after_loss();
        do_reset(1'b0, 1'b0);
        check_state(ST_SOFT_OFF);
        check_bit("supply_on_ff", 1'b0, supply_on_ff);
        wake(4'hA);
        check_state(ST_SOFT_OFF);
        wake(4'h4);
        check_state(ST_SOFT_OFF);
        wake(4'h1);
        check_state(ST_SOFT_OFF);
        short_press(POL_RAM);
        check_state(ST_WORKING);
        check_bit("supply_on_ff", 1'b1, supply_on_ff);
        check_bit("led_green_ff", 1'b1, led_green_ff);
    endtask
    task automatic t_ram_usb();
        @(posedge clock);
        led_dual <= 1'b1;
        short_press(POL_RAM);
        check_state(ST_RAM);
        check_bit("supply_on_ff", 1'b0, supply_on_ff);
        check_bit("led_amber_ff", 1'b1, led_amber_ff);
        wake(4'h4);
        check_state(ST_WORKING);
    endtask
    task automatic t_disk_pcie();
        short_press(POL_DISK);
        check_state(ST_DISK);
        wake(4'h4);
        check_state(ST_DISK);
        wake(4'h2);
        check_state(ST_WORKING);
    endtask
    task automatic t_off_rtc_lan();
        @(posedge clock);
        rtc_alarm_set <= 1'b1;
        short_press(POL_OFF);
        check_state(ST_SOFT_OFF);
        wake(4'h1);
        check_state(ST_WORKING);
        short_press(POL_OFF);
        wake(4'h8);
        check_state(ST_WORKING);
        os_sleep(POL_DISK);
        check_state(ST_DISK);
        wake(4'h2);
        check_state(ST_WORKING);
    endtask
    task automatic t_press_lengths();
        i_pwr_src_model.press(5000);
        settle();
        check_state(ST_WORKING);
        i_pwr_src_model.press(6500);
        settle();
        check_state(ST_SOFT_OFF);
    endtask
    task automatic t_on_after_loss_dark();
        do_reset(1'b1, 1'b1);
        check_state(ST_WORKING);
        @(posedge clock);
        led_dual <= 1'b0;
        short_press(POL_RAM);
        check_state(ST_RAM);
        check_bit("led_amber_ff", 1'b0, led_amber_ff);
        check_bit("led_green_ff", 1'b0, led_green_ff);
        wake(4'h2);
        check_state(ST_WORKING);
    endtask
    // Closing report
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        reset = 1'b1;
        rtc_alarm_set = 1'b0;
        restore_last = 1'b0;
        last_was_on = 1'b0;
        led_dual = 1'b1;
        sleep_policy = POL_RAM;
        os_sleep_req = 1'b0;
        t_off_after_loss();
        t_ram_usb();
        t_disk_pcie();
        t_off_rtc_lan();
        t_press_lengths();
        t_on_after_loss_dark();
        test_done();
    end
endmodule

// File: press_timer.sv
`timescale 1ns/1ps
`include "pwr_consts.svh"
// ************************************************
// Switch press timer
// ************************************************
module press_timer #(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic pressed,
    output logic release_short,
    output logic release_long,
    output logic hold_long
);
    logic [`MS_CNT_W-1:0] tick_ff;
    logic [`PRESS_CNT_W-1:0] ms_ff;
    logic pressed_d_ff;
    logic tick;

    // Refuse a prescale that the prescaler register cannot count
    if (MS_CYCLES < 1 || MS_CYCLES > (1 << `MS_CNT_W) - 1) begin : g_bad_prescale
        $error("MS_CYCLES out of range");
    end

    assign tick = (tick_ff == `MS_CNT_W'(MS_CYCLES - 1));

    // Millisecond prescaler, free running on the standby clock
    always_ff @(posedge clock) begin
        if (reset || tick) begin
            tick_ff <= '0;
        end else begin
            tick_ff <= tick_ff + 1'b1;
        end
    end

    // Press length in ms, saturating so a stuck switch cannot wrap
    always_ff @(posedge clock) begin
        if (reset || !pressed) begin
            ms_ff <= '0;
        end else if (tick && ms_ff != '1) begin
            ms_ff <= ms_ff + 1'b1; // R12
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pressed_d_ff <= 1'b0;
        end else begin
            pressed_d_ff <= pressed;
        end
    end

    // Short acts on release; long acts while still held
    assign release_short = pressed_d_ff && !pressed && ms_ff < `PRESS_CNT_W'(`PRESS_SHORT_MS);
    assign hold_long = pressed && ms_ff > `PRESS_CNT_W'(`PRESS_LONG_MS);
    assign release_long = pressed_d_ff && !pressed && ms_ff > `PRESS_CNT_W'(`PRESS_LONG_MS);
endmodule

// File: pwr_consts.svh
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH
// Press thresholds in milliseconds
`define PRESS_SHORT_MS 4000
`define PRESS_LONG_MS 6000
// Clock rate in kHz for millisecond conversion
`define CLOCK_KHZ 50000
// Tick divider: one tick per millisecond
`define MS_CYCLES (`CLOCK_KHZ)
`define MS_CNT_W 16
`define PRESS_CNT_W 16
`endif

// File: pwr_pkg.sv
package pwr_pkg;
    // System power states
    typedef enum logic [2:0] {
        ST_WORKING = 3'b000,
        ST_RAM = 3'b001,
        ST_DISK = 3'b010,
        ST_SOFT_OFF = 3'b011
    } pwr_state_type;
    // Wake request group
    typedef struct packed {
        logic lan;
        logic usb;
        logic pcie;
        logic rtc;
    } wake_req_type;
    // Power switch policy when working
    typedef enum logic [1:0] {
        POL_RAM = 2'b00,
        POL_DISK = 2'b01,
        POL_OFF = 2'b10
    } sleep_policy_type;
endpackage

// File: pwr_src_model.sv
`timescale 1ns/1ps
// ****************************************
// Front panel switch and wake source model
// ****************************************
module pwr_src_model #(
    parameter int MS_CYCLES = 2
) (
    input wire logic clock,
    output logic switch_pressed,
    output pwr_pkg::wake_req_type wake_in
);
    import pwr_pkg::*;
    // Idle: switch released, no wake request
    initial begin
        switch_pressed = 1'b0;
        wake_in = '0;
    end
    // Hold the switch for a number of milliseconds
    task automatic press(input int ms);
        @(posedge clock);
        switch_pressed <= 1'b1;
        repeat (ms * MS_CYCLES) @(posedge clock);
        switch_pressed <= 1'b0;
    endtask
    // Short pulse; a held level would wake again after the next sleep
    task automatic wake(input wake_req_type w);
        @(posedge clock);
        wake_in <= w;
        repeat (4) @(posedge clock);
        wake_in <= '0;
    endtask
endmodule
